// ==== logic/eeprom_frontend_pkg.sv ====
// Constants shared by the serial memory pin front end.
`default_nettype none
package eeprom_frontend_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int DESELECT_MIN_TIME_NS = 1000;
  localparam int DESELECT_CYCLES = (DESELECT_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SERIAL_CLOCK_MAX_RATE_KHZ = 250;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int OPCODE_W = 2;
  localparam int HEADER_BITS = OPCODE_W + ADDR_W;
  localparam logic [1:0] OP_MISC = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_WDS = 2'h0;
  localparam logic [1:0] SUB_WRITE_EVERY_WORD = 2'h1;
  localparam logic [1:0] SUB_ERAL = 2'h2;
  localparam logic [1:0] SUB_WEN = 2'h3;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;
endpackage : eeprom_frontend_pkg
`default_nettype wire

// ==== logic/pin_sync_edge.sv ====
// Two-flop synchroniser with edge detection for one pin.
`default_nettype none
module pin_sync_edge (
  input wire logic mclk,
  input wire logic rstSync_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic stage;
  logic prev;

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      meta <= 1'b0;
      stage <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      stage <= meta;
      prev <= stage;
    end
  end

  assign level = stage;
  assign rise = stage & ~prev;
  assign fall = ~stage & prev;
endmodule : pin_sync_edge
`default_nettype wire

// ==== logic/serial_eeprom_pin_frontend.sv ====
// Pin front end of a 256 x 16 serial memory: select gating, shift-in, read-out and program launch.
// Overview of operation
// - Select high means selected.
// - Transfers happen only while selected.
// - Select rising edge restarts the serial sequencer.
// - Select falling edge after write launches programming.
// - Clock and data ignored while deselected.
// - Input bit sampled on serial clock rise.
// - Output bit changes on serial clock rise.
// - Output driven only while selected.
// - Long deselect resets sequencer, header, data, output bit and armed flag; write enable and status mode are kept.
// - Start, opcode, address, optional sixteen data bits.
// - Read sends dummy zero then sixteen bits.
// - Reselect after launch reports busy or ready.
`default_nettype none
module serial_eeprom_pin_frontend
  import eeprom_frontend_pkg::*;
#(
  parameter int DESELECT_COUNT = DESELECT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chipSelect,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  output logic serialOut,
  output logic serialOutEn_n,
  output logic [eeprom_frontend_pkg::ADDR_W-1:0] memAddr,
  output logic memReadReq,
  input wire logic [eeprom_frontend_pkg::DATA_W-1:0] memReadData,
  output logic progStart,
  output logic [eeprom_frontend_pkg::OPCODE_W-1:0] progOpcode,
  output logic [eeprom_frontend_pkg::OPCODE_W-1:0] progSub,
  output logic [eeprom_frontend_pkg::ADDR_W-1:0] progAddr,
  output logic [eeprom_frontend_pkg::DATA_W-1:0] progData,
  output logic writeEnabled,
  input wire logic progBusy,
  output logic deviceReset
);
  import eeprom_frontend_pkg::*;

  typedef enum {ST_IDLE, ST_HEADER, ST_DATA, ST_READOUT, ST_DONE} state_e;

  logic rstMeta_n;
  logic rstSync_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  logic selected;
  logic selRise;
  logic selFall;
  logic sckRise;
  logic dinLevel;

  pin_sync_edge u_sel_sync (
    .mclk(mclk), .rstSync_n(rstSync_n), .pin(chipSelect),
    .level(selected), .rise(selRise), .fall(selFall)
  );
  pin_sync_edge u_sck_sync (
    .mclk(mclk), .rstSync_n(rstSync_n), .pin(serial_clock_in),
    .level(), .rise(sckRise), .fall()
  );
  pin_sync_edge u_din_sync (
    .mclk(mclk), .rstSync_n(rstSync_n), .pin(serial_in),
    .level(dinLevel), .rise(), .fall()
  );

  // Serial clock edges count only while selected.
  logic bitStrobe;
  assign bitStrobe = sckRise & selected;

  state_e state;
  state_e next_state;
  logic [4:0] bitCount;
  logic [4:0] next_bitCount;
  logic [HEADER_BITS-1:0] header;
  logic [HEADER_BITS-1:0] next_header;
  logic [DATA_W-1:0] shiftData;
  logic [DATA_W-1:0] next_shiftData;
  logic outBit;
  logic next_outBit;
  logic armed;
  logic next_armed;
  logic wen;
  logic next_wen;
  logic statusMode;
  logic next_statusMode;
  logic [15:0] lowCount;
  logic [15:0] next_lowCount;
  logic launch;
  logic [OPCODE_W-1:0] op;
  logic [OPCODE_W-1:0] sub;

  assign op = header[HEADER_BITS-1 -: OPCODE_W];
  assign sub = header[ADDR_W-1 -: OPCODE_W];
  assign launch = selFall & armed;
  assign deviceReset = !selected && (lowCount >= 16'(DESELECT_COUNT));

  always_comb begin
    next_state = state;
    next_bitCount = bitCount;
    next_header = header;
    next_shiftData = shiftData;
    next_outBit = outBit;
    next_armed = armed;
    next_wen = wen;
    next_statusMode = statusMode;
    next_lowCount = selected ? 16'h0000 : ((lowCount == 16'hffff) ? lowCount : lowCount + 16'h0001);
    if (selRise) begin
      next_state = ST_IDLE;
      next_bitCount = 5'h00;
      next_outBit = 1'b1;
    end else if (launch) begin
      next_armed = 1'b0;
      next_statusMode = 1'b1;
      next_state = ST_IDLE;
    end else if (selFall && state == ST_DONE && op == OP_MISC) begin
      if (sub == SUB_WEN) next_wen = 1'b1;
      if (sub == SUB_WDS) next_wen = 1'b0;
    end else if (bitStrobe) begin
      next_statusMode = 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (dinLevel) begin
            next_state = ST_HEADER;
            next_bitCount = 5'h00;
          end
        end
        ST_HEADER: begin
          next_header = {header[HEADER_BITS-2:0], dinLevel};
          next_bitCount = bitCount + 5'h01;
          if (bitCount == 5'(HEADER_BITS - 1)) begin
            next_bitCount = 5'h00;
            if (header[HEADER_BITS-2 -: OPCODE_W] == OP_READ) begin
              next_state = ST_READOUT;
              next_outBit = 1'b0;
            end else if (header[HEADER_BITS-2 -: OPCODE_W] == OP_WRITE ||
                         (header[HEADER_BITS-2 -: OPCODE_W] == OP_MISC &&
                          header[ADDR_W-2 -: 2] == SUB_WRITE_EVERY_WORD)) begin
              next_state = ST_DATA;
            end else begin
              next_state = ST_DONE;
              next_armed = (header[HEADER_BITS-2 -: OPCODE_W] == OP_ERASE ||
                            (header[HEADER_BITS-2 -: OPCODE_W] == OP_MISC &&
                             header[ADDR_W-2 -: 2] == SUB_ERAL)) && wen;
            end
          end
        end
        ST_DATA: begin
          next_shiftData = {shiftData[DATA_W-2:0], dinLevel};
          next_bitCount = bitCount + 5'h01;
          if (bitCount == 5'(DATA_W - 1)) begin
            next_state = ST_DONE;
            next_armed = wen;
          end
        end
        ST_READOUT: begin
          // Each clock rise launches the next output bit.
          next_bitCount = bitCount + 5'h01;
          next_outBit = (bitCount == 5'h00) ? memReadData[DATA_W-1] : shiftData[DATA_W-1];
          next_shiftData = (bitCount == 5'h00) ? {memReadData[DATA_W-2:0], 1'b0} : {shiftData[DATA_W-2:0], 1'b0};
          if (bitCount == 5'(DATA_W)) begin
            next_state = ST_DONE;
            next_outBit = 1'b0;
          end
        end
        ST_DONE: begin
          next_armed = 1'b0;
        end
      endcase
    end
    if (deviceReset) begin
      next_state = ST_IDLE;
      next_bitCount = 5'h00;
      next_header = '0;
      next_shiftData = DATA_RESET;
      next_armed = 1'b0;
      next_outBit = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state <= ST_IDLE;
      bitCount <= 5'h00;
      header <= '0;
      shiftData <= DATA_RESET;
      outBit <= 1'b1;
      armed <= 1'b0;
      wen <= 1'b0;
      statusMode <= 1'b0;
      lowCount <= 16'h0000;
    end else begin
      state <= next_state;
      bitCount <= next_bitCount;
      header <= next_header;
      shiftData <= next_shiftData;
      outBit <= next_outBit;
      armed <= next_armed;
      wen <= next_wen;
      statusMode <= next_statusMode;
      lowCount <= next_lowCount;
    end
  end

  logic progReg;
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      progReg <= 1'b0;
      progOpcode <= OP_MISC;
      progSub <= SUB_WDS;
      progAddr <= ADDR_RESET;
      progData <= DATA_RESET;
      serialOut <= 1'b0;
      serialOutEn_n <= 1'b1;
    end else begin
      progReg <= launch;
      if (launch) begin
        progOpcode <= op;
        progSub <= sub;
        progAddr <= header[ADDR_W-1:0];
        progData <= shiftData;
      end
      serialOut <= statusMode ? ~progBusy : outBit;
      serialOutEn_n <= ~selected;
    end
  end

  assign progStart = progReg;
  assign memAddr = header[ADDR_W-1:0];
  assign memReadReq = (state == ST_READOUT) && (bitCount == 5'h00);
  assign writeEnabled = wen;
endmodule : serial_eeprom_pin_frontend
`default_nettype wire

// ==== verif/serial_eeprom_pin_frontend_assertions.sv ====
// Port-level checks for the serial memory pin front end.
`default_nettype none
module fe_checker #(parameter int DESELECT_COUNT = 20) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chipSelect,
  input wire logic serial_clock_in,
  input wire logic serialOut,
  input wire logic serialOutEn_n,
  input wire logic memReadReq,
  input wire logic progStart,
  input wire logic writeEnabled,
  input wire logic progBusy,
  input wire logic deviceReset
);
  int lowCnt;
  int next_lowCnt;
  always_comb next_lowCnt = chipSelect ? 0 : lowCnt + 32'(lowCnt < 1000);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) lowCnt <= 0;
    else lowCnt <= next_lowCnt;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  out_off_a: assert property (!chipSelect [*8] |-> serialOutEn_n) else $error("output not released");
  out_on_a: assert property (chipSelect [*8] |-> !serialOutEn_n) else $error("output not driven");
  launch_pulse_a: assert property (progStart |=> !progStart) else $error("launch too long");
  launch_edge_a: assert property (progStart |-> !chipSelect && $past(chipSelect, 10))
    else $error("launch without select fall");
  launch_enable_a: assert property (progStart |-> writeEnabled) else $error("launch while disabled");
  long_deselect_a: assert property (lowCnt >= DESELECT_COUNT + 8 |-> deviceReset) else $error("no reset");
  out_hold_a: assert property (($stable(serial_clock_in) && $stable(chipSelect) && $stable(progBusy) &&
    $stable(deviceReset)) [*8] |-> $stable(serialOut)) else $error("output moved without clock");
  read_select_a: assert property (memReadReq |-> !serialOutEn_n) else $error("read while deselected");
  cover property (progStart);
  cover property (memReadReq);
  cover property ($rose(deviceReset));
endmodule : fe_checker
bind serial_eeprom_pin_frontend fe_checker #(.DESELECT_COUNT(DESELECT_COUNT)) fe_checker_i (.mclk(mclk),
  .rst_n(rst_n), .chipSelect(chipSelect), .serial_clock_in(serial_clock_in), .serialOut(serialOut),
  .serialOutEn_n(serialOutEn_n), .memReadReq(memReadReq), .progStart(progStart),
  .writeEnabled(writeEnabled), .progBusy(progBusy), .deviceReset(deviceReset));
`default_nettype wire

// ==== verif/host.sv ====
// Controlling master that drives select, clock and data pins.
`default_nettype none
module host (
  input wire logic mclk,
  input wire logic serialOut,
  input wire logic serialOutEn_n,
  output logic chipSelect,
  output logic serialClock,
  output logic serialData,
  output logic lineLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chipSelect <= 1'b0;
    serialClock <= 1'b0;
    serialData <= 1'b0;
  end
  // A released line shows the inverse of the current serialOut, never serialOut itself.
  assign lineLevel = serialOutEn_n ? ~serialOut : serialOut;
  // Each select change is held longer than the deselect interval.
  task automatic sel(input logic v);
    @(posedge mclk) chipSelect <= v;
    repeat (40) @(posedge mclk);
  endtask : sel
  // The reply is sampled late in each high phase of the clock.
  task automatic xfer(input logic [28:0] bits, output logic [28:0] got);
    got = '0;
    for (int i = 28; i >= 0; i--) begin
      @(posedge mclk) serialData <= bits[i];
      repeat (12) @(posedge mclk);
      serialClock <= 1'b1;
      repeat (12) @(posedge mclk);
      got = {got[27:0], lineLevel};
      serialClock <= 1'b0;
    end
    repeat (13) @(posedge mclk);
  endtask : xfer
endmodule : host
`default_nettype wire

// ==== verif/test_serial_eeprom_pin_frontend.sv ====
// Self-checking bench for the serial memory pin front end.
`default_nettype none
module test_serial_eeprom_pin_frontend;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_frontend_pkg::*;
  logic mclk;
  logic rst_n;
  logic progBusy;
  logic chipSelect, serialClock, serialData, lineLevel, serialOut, serialOutEn_n;
  logic memReadReq, progStart, writeEnabled, deviceReset;
  logic [ADDR_W-1:0] memAddr, progAddr;
  logic [DATA_W-1:0] memReadData;
  logic [ADDR_W-1:0] reqAddr;
  logic [DATA_W-1:0] progData;
  logic [OPCODE_W-1:0] progOpcode, progSub;
  logic [28:0] got;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int busyLeft = 0;
  int nStart = 0;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // The array answers with a word made from its address and stays busy for 300 cycles after each launch.
  always @(posedge mclk) begin
    memReadData <= {memAddr, ~memAddr};
    if (memReadReq) reqAddr <= memAddr;
    busyLeft <= progStart ? 300 : busyLeft - 32'(busyLeft > 0);
    progBusy <= progStart || busyLeft > 1;
    nStart <= nStart + 32'(progStart);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  serial_eeprom_pin_frontend #(.DESELECT_COUNT(20)) serial_eeprom_pin_frontend_i (.mclk(mclk), .rst_n(rst_n),
    .chipSelect(chipSelect), .serial_clock_in(serialClock), .serial_in(serialData), .serialOut(serialOut),
    .serialOutEn_n(serialOutEn_n), .memAddr(memAddr), .memReadReq(memReadReq), .memReadData(memReadData),
    .progStart(progStart), .progOpcode(progOpcode), .progSub(progSub), .progAddr(progAddr),
    .progData(progData), .writeEnabled(writeEnabled), .progBusy(progBusy), .deviceReset(deviceReset));
  host host_i (.mclk(mclk), .serialOut(serialOut), .serialOutEn_n(serialOutEn_n), .chipSelect(chipSelect),
    .serialClock(serialClock), .serialData(serialData), .lineLevel(lineLevel));
  task automatic chk(input string what, input logic [25:0] exp, input logic [25:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic t_read(input logic [7:0] a);
    host_i.sel(1'b1);
    chk("enable", 26'h0, 26'(serialOutEn_n));
    host_i.xfer({3'b001, OP_READ, a, 16'h0}, got);
    chk("address", 26'(a), 26'(memAddr));
    chk("request", 26'(a), 26'(reqAddr));
    chk("read word", 26'({1'b0, a, ~a}), 26'(got[16:0]));
    host_i.sel(1'b0);
    chk("enable", 26'h1, 26'(serialOutEn_n));
    chk("reset", 26'h1, 26'(deviceReset));
    $display("read test done");
  endtask : t_read
  task automatic t_refuse();
    host_i.xfer({3'b001, OP_READ, 8'h3c, 16'h0}, got);
    chk("idle enable", 26'h1, 26'(serialOutEn_n));
    host_i.sel(1'b1);
    host_i.xfer({3'b001, OP_WRITE, 8'h11, 16'hbeef}, got);
    host_i.sel(1'b0);
    chk("launches", 26'h0, 26'(nStart));
    $display("refuse test done");
  endtask : t_refuse
  task automatic t_write();
    host_i.sel(1'b1);
    host_i.xfer({19'h1, OP_MISC, SUB_WEN, 6'h0}, got);
    host_i.sel(1'b0);
    chk("enabled", 26'h1, 26'(writeEnabled));
    host_i.sel(1'b1);
    host_i.xfer({3'b001, OP_WRITE, 8'h5c, 16'hc3a1}, got);
    host_i.sel(1'b0);
    chk("launches", 26'h1, 26'(nStart));
    chk("program", {OP_WRITE, 8'h5c, 16'hc3a1}, {progOpcode, progAddr, progData});
    chk("program sub", 26'h1, 26'(progSub));
    host_i.sel(1'b1);
    chk("busy", 26'h0, 26'(lineLevel));
    repeat (300) @(posedge mclk);
    chk("ready", 26'h1, 26'(lineLevel));
    host_i.sel(1'b0);
    $display("write test done");
  endtask : t_write
  task automatic t_others();
    host_i.sel(1'b1);
    host_i.xfer({3'b001, OP_MISC, SUB_WRITE_EVERY_WORD, 6'h0, 16'h1234}, got);
    host_i.sel(1'b0);
    chk("fill launches", 26'h2, 26'(nStart));
    chk("fill", 26'({OP_MISC, SUB_WRITE_EVERY_WORD, 16'h1234}), 26'({progOpcode, progSub, progData}));
    host_i.sel(1'b1);
    host_i.xfer({19'h1, OP_ERASE, 8'h77}, got);
    host_i.sel(1'b0);
    chk("erase launches", 26'h3, 26'(nStart));
    chk("erase", 26'({OP_ERASE, 8'h77}), 26'({progOpcode, progAddr}));
    host_i.sel(1'b1);
    host_i.xfer({19'h1, OP_MISC, SUB_WDS, 6'h3f}, got);
    host_i.sel(1'b0);
    chk("disabled", 26'h0, 26'(writeEnabled));
    $display("others test done");
  endtask : t_others
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  initial begin
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    t_read(8'ha5);
    t_refuse();
    t_write();
    t_others();
    t_read(8'h3c);
    test_done();
  end
endmodule : test_serial_eeprom_pin_frontend
`default_nettype wire
